// ### rtl/ramp_pkg.sv
package ramp_pkg;

    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned RST_HOLD_CYC = 3;

    localparam logic [3:0] A_CMD  = 4'h0;
    localparam logic [3:0] A_CTL  = 4'h1;
    localparam logic [3:0] A_RSEL = 4'h2;
    localparam logic [3:0] A_OMD  = 4'h3;
    localparam logic [3:0] A_MAIN_STATUS = 4'h4;
    localparam logic [3:0] A_FEED = 4'h5;
    localparam logic [3:0] A_FL   = 4'h6;
    localparam logic [3:0] A_FH   = 4'h7;
    localparam logic [3:0] A_RATE = 4'h8;
    localparam logic [3:0] A_SCL  = 4'h9;
    localparam logic [3:0] A_SDP  = 4'ha;
    localparam logic [3:0] A_IDLE = 4'hb;
    localparam logic [3:0] A_CNT  = 4'hc;
    localparam logic [3:0] A_IOP  = 4'hd;
    localparam logic [3:0] A_SPD  = 4'he;
    localparam logic [3:0] A_ENV  = 4'hf;

    localparam logic [7:0]  CMD_HI_SPEED = 8'h15;
    localparam logic [7:0]  CMD_STOP     = 8'h08;
    localparam logic [7:0]  RST_START    = 8'h00;
    localparam logic [7:0]  RST_CTL      = 8'h40;
    localparam logic [7:0]  RST_RSEL     = 8'h80;
    localparam logic [7:0]  RST_OMD_PAR  = 8'hc0;
    localparam logic [7:0]  RST_OMD_SER  = 8'he0;
    localparam logic [7:0]  RST_MAIN_STATUS     = 8'h37;
    localparam logic [23:0] RST_ENV_PAR  = 24'h000000;
    localparam logic [23:0] RST_ENV_SER  = 24'h000002;
    localparam logic [3:0]  RST_PH_UNI   = 4'h9;
    localparam logic [3:0]  RST_PH_BI    = 4'h1;

    localparam int unsigned SCURVE_BIT = 5;
    localparam int unsigned AUTO_SLOWDOWN_SEL_BIT   = 3;
    localparam logic [22:0] ACC_MAX    = 23'h7fffff;
    localparam logic [9:0]  SCALE_MIN  = 10'h002;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ACCEL = 3'b001,
        ST_CONST = 3'b010,
        ST_DECEL = 3'b011,
        ST_TAIL  = 3'b100
    } state_t;

    typedef struct packed {
        logic [12:0] start;
        logic [12:0] run;
        logic [15:0] rate;
        logic [9:0]  scale;
    } prof_t;

endpackage

// ### rtl/step_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
module step_rate_gen #(
    parameter int unsigned SW = 13,
    parameter int unsigned MW = 10
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          en,
    input  wire logic [SW-1:0] speed,
    input  wire logic [MW-1:0] scale,
    output logic               step
);
    logic [MW-1:0] pre_q;
    logic [SW-1:0] acc_q;
    logic [SW:0]   sum;
    logic [MW-1:0] lim;
    logic          tick;

    // scale below its floor would run faster than defined
    assign lim  = (scale < ramp_pkg::SCALE_MIN) ? ramp_pkg::SCALE_MIN : scale;
    assign tick = en && (pre_q >= lim - 1'b1);
    assign sum  = {1'b0, acc_q} + {1'b0, speed};

    // pulses per second = speed * clk / (scale * 2^SW)
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pre_q <= '0;
        else if (!en || tick)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_q <= '0;
            step  <= 1'b0;
        end
        else if (!en)
        begin
            acc_q <= '0;
            step  <= 1'b0;
        end
        else
        begin
            step <= tick && sum[SW];
            if (tick)
                acc_q <= sum[SW-1:0];
        end
    end
endmodule // step_rate_gen
`default_nettype wire

// ### rtl/ramp_profile_gen.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ramp_profile_gen #(
    parameter bit SERIAL_IF = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [23:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [23:0] rdata,
    input  wire logic        unipolar_bipolar_sel,
    output logic             int_out,
    output logic             wait_request_out,
    output logic             plus_pulse_out,
    output logic             minus_pulse_or_direction_out,
    output logic             busy_out,
    output logic             timer_done_out,
    output logic             phase_out_1,
    output logic             phase_out_2,
    output logic             phase_out_3,
    output logic             phase_out_4
);
    ramp_pkg::state_t state_q;
    ramp_pkg::prof_t  prof_q;
    logic [7:0]  start_mode_q;
    logic [7:0]  ctl_q;
    logic [7:0]  rsel_q;
    logic [7:0]  omd_q;
    logic [7:0]  main_status;
    logic [23:0] feed_amount_reg;
    logic [23:0] slowdown_point_reg;
    logic [2:0]  idle_pulse_count_reg;
    logic [23:0] position_counter_reg;
    logic [7:0]  io_port_reg;
    logic [23:0] environment_reg;
    logic [12:0] current_speed_reg;
    logic [12:0] tgt_q;
    logic [22:0] acc_cnt_q;
    logic [2:0]  idle_left_q;
    logic [16:0] rcnt_q;
    logic [3:0]  phase_q;
    logic        slow_q;
    logic        stage_q;
    logic        init_q;

    logic        scurve_sel;
    logic        auto_slowdown_sel;
    logic        step;
    logic        gen_en;
    logic        running;
    logic        start_cmd;
    logic        stop_cmd;
    logic        ramping;
    logic        rtick;
    logic [16:0] rint;
    logic signed [25:0] sd_pt;
    logic        slow_hit;
    logic [12:0] goal;
    logic [12:0] floor_spd;

    ////////////////////////////////////////////////////////////////////////
    assign scurve_sel        = ctl_q[ramp_pkg::SCURVE_BIT];
    assign auto_slowdown_sel = environment_reg[ramp_pkg::AUTO_SLOWDOWN_SEL_BIT];
    assign running   = (state_q != ramp_pkg::ST_IDLE);
    // no pulse may leave once the feed is used up
    assign gen_en    = running && (feed_amount_reg != '0);
    assign start_cmd = wr && addr == ramp_pkg::A_CMD
                       && wdata[7:0] == ramp_pkg::CMD_HI_SPEED;
    assign stop_cmd  = wr && addr == ramp_pkg::A_CMD
                       && wdata[7:0] == ramp_pkg::CMD_STOP;

    // auto: learned count plus signed offset; manual: plain pulse count
    assign sd_pt = auto_slowdown_sel
        ? $signed({3'b000, acc_cnt_q}) + 26'($signed(slowdown_point_reg))
        : $signed({2'b00, slowdown_point_reg});
    assign slow_hit = $signed({2'b00, feed_amount_reg}) <= sd_pt;

    // s-curve caps at the target latched at accel start
    assign goal = (scurve_sel && tgt_q < prof_q.run) ? tgt_q : prof_q.run;
    assign floor_spd = (slow_q || (scurve_sel && stage_q
                        && prof_q.run < prof_q.start))
                       ? prof_q.start : prof_q.run;

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_mode_q <= ramp_pkg::RST_START;
            ctl_q        <= ramp_pkg::RST_CTL;
            rsel_q       <= ramp_pkg::RST_RSEL;
            omd_q        <= SERIAL_IF ? ramp_pkg::RST_OMD_SER
                                      : ramp_pkg::RST_OMD_PAR;
            environment_reg <= SERIAL_IF ? ramp_pkg::RST_ENV_SER
                                         : ramp_pkg::RST_ENV_PAR;
            prof_q               <= '0;
            slowdown_point_reg   <= '0;
            idle_pulse_count_reg <= '0;
            io_port_reg          <= '0;
        end
        else if (wr)
        begin
            unique case (addr)
                ramp_pkg::A_CMD:  start_mode_q <= wdata[7:0];
                ramp_pkg::A_CTL:  ctl_q        <= wdata[7:0];
                ramp_pkg::A_RSEL: rsel_q       <= wdata[7:0];
                ramp_pkg::A_OMD:  omd_q        <= wdata[7:0];
                // speed and rate act live on the running profile
                ramp_pkg::A_FL:   prof_q.start <= wdata[12:0];
                ramp_pkg::A_FH:   prof_q.run   <= wdata[12:0];
                ramp_pkg::A_RATE: prof_q.rate  <= wdata[15:0];
                ramp_pkg::A_SCL:  prof_q.scale <= wdata[9:0];
                ramp_pkg::A_SDP:  slowdown_point_reg   <= wdata;
                ramp_pkg::A_IDLE: idle_pulse_count_reg <= wdata[2:0];
                ramp_pkg::A_IOP:  io_port_reg          <= wdata[7:0];
                ramp_pkg::A_ENV:  environment_reg      <= wdata;
                default: ;
            endcase
        end
    end

    // feed counts down per pulse; a host write wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            feed_amount_reg <= '0;
        else if (wr && addr == ramp_pkg::A_FEED)
            feed_amount_reg <= wdata;
        else if (step && feed_amount_reg != '0)
            feed_amount_reg <= feed_amount_reg - 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            position_counter_reg <= '0;
        else if (wr && addr == ramp_pkg::A_CNT)
            position_counter_reg <= wdata;
        else if (step)
            position_counter_reg <= position_counter_reg + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, data valid in the following cycle only
    function automatic logic [23:0] reg_read(input logic [3:0] a);
        unique case (a)
            ramp_pkg::A_CMD:  reg_read = {16'h0000, start_mode_q};
            ramp_pkg::A_CTL:  reg_read = {16'h0000, ctl_q};
            ramp_pkg::A_RSEL: reg_read = {16'h0000, rsel_q};
            ramp_pkg::A_OMD:  reg_read = {16'h0000, omd_q};
            ramp_pkg::A_MAIN_STATUS: reg_read = {16'h0000, main_status};
            ramp_pkg::A_FEED: reg_read = feed_amount_reg;
            ramp_pkg::A_FL:   reg_read = {11'h000, prof_q.start};
            ramp_pkg::A_FH:   reg_read = {11'h000, prof_q.run};
            ramp_pkg::A_RATE: reg_read = {8'h00, prof_q.rate};
            ramp_pkg::A_SCL:  reg_read = {14'h0000, prof_q.scale};
            ramp_pkg::A_SDP:  reg_read = slowdown_point_reg;
            ramp_pkg::A_IDLE: reg_read = {21'h000000, idle_pulse_count_reg};
            ramp_pkg::A_CNT:  reg_read = position_counter_reg;
            ramp_pkg::A_IOP:  reg_read = {16'h0000, io_port_reg};
            ramp_pkg::A_SPD:  reg_read = {11'h000, current_speed_reg};
            ramp_pkg::A_ENV:  reg_read = environment_reg;
        endcase
    endfunction

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= '0;
        else
            rdata <= rd ? reg_read(addr) : 24'h000000;
    end

    // bit 0 shows idle; upper bits hold their reset pattern
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            main_status <= ramp_pkg::RST_MAIN_STATUS;
        else
            main_status <= {ramp_pkg::RST_MAIN_STATUS[7:1], !running};
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp step timer: one speed unit per rate clocks, doubled for s-curve
    assign ramping = (state_q == ramp_pkg::ST_ACCEL && idle_left_q == '0)
                     || state_q == ramp_pkg::ST_DECEL;
    assign rint = scurve_sel ? {prof_q.rate, 1'b0} : {1'b0, prof_q.rate};
    assign rtick = ramping && (rcnt_q + 1'b1 >= rint);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rcnt_q <= '0;
        else if (!ramping || rtick)
            rcnt_q <= '0;
        else
            rcnt_q <= rcnt_q + 1'b1;
    end

    step_rate_gen #(
        .SW (13),
        .MW (10)
    ) u_rate (
        .clk   (clk),
        .nrst  (nrst),
        .en    (gen_en),
        .speed (current_speed_reg),
        .scale (prof_q.scale),
        .step  (step)
    );

    ////////////////////////////////////////////////////////////////////////
    // profile sequencer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q           <= ramp_pkg::ST_IDLE;
            current_speed_reg <= '0;
            tgt_q             <= '0;
            slow_q            <= 1'b0;
            stage_q           <= 1'b0;
            idle_left_q       <= '0;
        end
        else if (stop_cmd)
            state_q <= ramp_pkg::ST_IDLE;
        else if (!running)
        begin
            current_speed_reg <= '0;
            if (start_cmd && feed_amount_reg != '0)
            begin
                state_q           <= ramp_pkg::ST_ACCEL;
                current_speed_reg <= prof_q.start;
                tgt_q             <= prof_q.run;
                slow_q            <= 1'b0;
                stage_q           <= 1'b0;
                idle_left_q       <= idle_pulse_count_reg;
            end
        end
        else if (feed_amount_reg == '0)
            state_q <= ramp_pkg::ST_IDLE;
        else if (!slow_q && slow_hit && state_q != ramp_pkg::ST_TAIL)
        begin
            slow_q  <= 1'b1;
            state_q <= ramp_pkg::ST_DECEL;
        end
        else
        begin
            unique case (state_q)
                ramp_pkg::ST_ACCEL:
                begin
                    if (step && idle_left_q != '0)
                        idle_left_q <= idle_left_q - 1'b1;
                    if (rtick)
                    begin
                        if (prof_q.run < current_speed_reg)
                        begin
                            state_q <= ramp_pkg::ST_DECEL;
                            stage_q <= 1'b1;
                        end
                        else if (current_speed_reg < goal)
                            current_speed_reg <= current_speed_reg + 1'b1;
                        else if (scurve_sel && prof_q.run > current_speed_reg)
                            tgt_q <= prof_q.run;
                        else
                            state_q <= ramp_pkg::ST_CONST;
                    end
                end
                ramp_pkg::ST_CONST:
                begin
                    if (prof_q.run > current_speed_reg)
                    begin
                        state_q <= ramp_pkg::ST_ACCEL;
                        tgt_q   <= prof_q.run;
                    end
                    else if (prof_q.run < current_speed_reg)
                        state_q <= ramp_pkg::ST_DECEL;
                end
                ramp_pkg::ST_DECEL:
                begin
                    if (rtick)
                    begin
                        if (current_speed_reg > floor_spd)
                            current_speed_reg <= current_speed_reg - 1'b1;
                        else if (slow_q)
                            state_q <= ramp_pkg::ST_TAIL;
                        else if (stage_q && scurve_sel
                                 && prof_q.run < current_speed_reg)
                            stage_q <= 1'b0;
                        else if (!slow_q && prof_q.run > current_speed_reg)
                        begin
                            state_q <= ramp_pkg::ST_ACCEL;
                            tgt_q   <= prof_q.run;
                        end
                        else
                            state_q <= ramp_pkg::ST_CONST;
                    end
                end
                ramp_pkg::ST_TAIL:
                    current_speed_reg <= prof_q.start;
                default:
                    state_q <= ramp_pkg::ST_IDLE;
            endcase
        end
    end

    // pulses spent accelerating; repeated run changes let it drift
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            acc_cnt_q <= '0;
        else if (start_cmd && !running)
            acc_cnt_q <= '0;
        else if (step && state_q == ramp_pkg::ST_ACCEL
                 && acc_cnt_q != ramp_pkg::ACC_MAX)
            acc_cnt_q <= acc_cnt_q + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // pins; reset is asynchronous and must be held over three clocks
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            plus_pulse_out               <= 1'b1;
            minus_pulse_or_direction_out <= 1'b1;
            busy_out                     <= 1'b1;
            int_out                      <= 1'b1;
            wait_request_out             <= 1'b1;
            timer_done_out               <= 1'b0;
        end
        else
        begin
            plus_pulse_out               <= !step;
            minus_pulse_or_direction_out <= 1'b1;
            busy_out                     <= !running;
            int_out                      <= 1'b1;
            wait_request_out             <= 1'b1;
            timer_done_out               <= 1'b0;
        end
    end

    // drive select is caught on the first edge after release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_q <= ramp_pkg::RST_PH_UNI;
            init_q  <= 1'b0;
        end
        else if (!init_q)
        begin
            init_q  <= 1'b1;
            phase_q <= unipolar_bipolar_sel ? ramp_pkg::RST_PH_BI
                                            : ramp_pkg::RST_PH_UNI;
        end
    end

    assign phase_out_1 = phase_q[0];
    assign phase_out_2 = phase_q[1];
    assign phase_out_3 = phase_q[2];
    assign phase_out_4 = phase_q[3];

    ////////////////////////////////////////////////////////////////////////
    chk_manual_slow: assert property (@(posedge clk) disable iff (!nrst)
        running && !stop_cmd && !slow_q && !auto_slowdown_sel
        && feed_amount_reg != '0 && state_q != ramp_pkg::ST_TAIL
        && feed_amount_reg <= slowdown_point_reg
        |=> slow_q && state_q == ramp_pkg::ST_DECEL)
        else $error("slow-down not entered at manual point");

    chk_auto_learn: assert property (@(posedge clk) disable iff (!nrst)
        step && state_q == ramp_pkg::ST_ACCEL && acc_cnt_q < ramp_pkg::ACC_MAX
        |=> acc_cnt_q == $past(acc_cnt_q) + 1'b1)
        else $error("accel pulse count missed a pulse");

    chk_start_cmd: assert property (@(posedge clk) disable iff (!nrst)
        start_cmd && !running && feed_amount_reg != '0
        |=> state_q == ramp_pkg::ST_ACCEL ##1 !busy_out)
        else $error("start command did not start motion");

    chk_stop_zero: assert property (@(posedge clk) disable iff (!nrst)
        running && feed_amount_reg == '0 |=> state_q == ramp_pkg::ST_IDLE)
        else $error("motion continued with no feed left");

    chk_feed_down: assert property (@(posedge clk) disable iff (!nrst)
        step && !wr && feed_amount_reg != '0
        |=> feed_amount_reg == $past(feed_amount_reg) - 1'b1)
        else $error("feed amount not decremented on pulse");

    chk_speed_step: assert property (@(posedge clk) disable iff (!nrst)
        $past(rtick) == 1'b0 && $past(state_q) != ramp_pkg::ST_IDLE
        && $past(state_q) != ramp_pkg::ST_TAIL && running
        |-> $stable(current_speed_reg))
        else $error("speed changed without a ramp tick");

    chk_reset_vals: assert property (@(posedge clk) disable iff (!nrst)
        !init_q |-> ctl_q == ramp_pkg::RST_CTL && rsel_q == ramp_pkg::RST_RSEL
        && start_mode_q == ramp_pkg::RST_START && busy_out && !timer_done_out)
        else $error("reset values wrong after release");

    chk_phase_init: assert property (@(posedge clk) disable iff (!nrst)
        $rose(init_q) |-> phase_q == ($past(unipolar_bipolar_sel)
        ? ramp_pkg::RST_PH_BI : ramp_pkg::RST_PH_UNI))
        else $error("phase reset pattern wrong");

    chk_pulse_low: assert property (@(posedge clk) disable iff (!nrst)
        !plus_pulse_out |=> plus_pulse_out)
        else $error("pulse output low for more than a cycle");
endmodule // ramp_profile_gen
`default_nettype wire

// ### verification/step_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
module step_driver_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic step_n,
    output int        steps
);
    // the driver counts one step for every low cycle on its step line
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            steps <= 0;
        else if (!step_n)
            steps <= steps + 1;
    end
endmodule // step_driver_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0, rd_d = 0, sel = 0;
    logic [3:0]  addr = 4'h0;
    logic [23:0] wdata = 24'h0, rdata, feed, e_v;
    logic        i_o, w_o, pls, mdir, busy, td, p1, p2, p3, p4;
    int          n_mismatch = 0, compares = 0, steps, total = 0, base;
    logic [23:0] exp_q[$];
    string       nm_q[$], n_v;
    logic [23:0] rst_tab[16] = '{1: 24'h40, 2: 24'h80, 3: 24'hc0,
                                 4: 24'h37, default: 24'h0};
    initial forever #50 clk = ~clk;
    ramp_profile_gen u_dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .unipolar_bipolar_sel(sel), .int_out(i_o), .wait_request_out(w_o),
        .plus_pulse_out(pls), .minus_pulse_or_direction_out(mdir),
        .busy_out(busy), .timer_done_out(td), .phase_out_1(p1),
        .phase_out_2(p2), .phase_out_3(p3), .phase_out_4(p4));
    step_driver_model u_drv (.clk(clk), .nrst(nrst), .step_n(pls),
        .steps(steps));
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d && exp_q.size() > 0)
        begin
            e_v = exp_q.pop_front();
            n_v = nm_q.pop_front();
            `CHK(n_v, e_v, rdata)
        end
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [23:0] e,
                          input string n);
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wait_idle;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 20000 && busy !== 1'b1; i++)
            @(posedge clk);
        if (busy !== 1'b1)
        begin
            n_mismatch++;
            give_verdict;
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic move(input logic [23:0] f, input logic [23:0] sdp);
        wr_reg(ramp_pkg::A_FEED, f);
        wr_reg(ramp_pkg::A_SDP, sdp);
        base = steps;
        wr_reg(ramp_pkg::A_CMD, {16'h0, ramp_pkg::CMD_HI_SPEED});
    endtask
    task automatic done_move(input logic [23:0] f);
        wait_idle;
        total += int'(f);
        `CHK("steps", f, 24'(steps - base))
        rd_chk(ramp_pkg::A_FEED, 24'h0, "feed");
        rd_chk(ramp_pkg::A_CNT, 24'(total), "counter");
    endtask
    initial
    begin
        void'($urandom(32'h0f87cf6b));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("pins", 10'h3e9, {i_o, w_o, pls, mdir, busy, td, p1, p2, p3, p4})
        for (int a = 0; a < 16; a++)
            rd_chk(4'(a), rst_tab[a], "reset value");
        $display("reset values done");
        wr_reg(ramp_pkg::A_SCL, 24'd2);
        wr_reg(ramp_pkg::A_FL, 24'd4000);
        wr_reg(ramp_pkg::A_FH, 24'd8000);
        wr_reg(ramp_pkg::A_RATE, 24'd1);
        feed = 24'd50 + 24'($urandom % 250);
        move(feed, 24'h0);
        done_move(feed);
        move(24'd4000, 24'd1464);
        done_move(24'd4000);
        wr_reg(ramp_pkg::A_CMD, {16'h0, ramp_pkg::CMD_HI_SPEED});
        repeat (3) @(posedge clk);
        `CHK("busy", 1'b1, busy)
        wr_reg(ramp_pkg::A_RATE, 24'd100);
        move(24'd200, 24'd200);
        repeat (300) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd4000, "speed");
        done_move(24'd200);
        wr_reg(ramp_pkg::A_ENV, 24'h8);
        wr_reg(ramp_pkg::A_RATE, 24'd1);
        move(feed, 24'd16);
        done_move(feed);
        move(feed, 24'hfffff0);
        done_move(feed);
        $display("positioning done");
        wr_reg(ramp_pkg::A_ENV, 24'h0);
        move(24'd100000, 24'h0);
        repeat (1000) @(posedge clk);
        wr_reg(ramp_pkg::A_FH, 24'd4500);
        repeat (1000) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd4500, "speed");
        wr_reg(ramp_pkg::A_FH, 24'd6000);
        repeat (2000) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd6000, "speed");
        wr_reg(ramp_pkg::A_FH, 24'd3000);
        repeat (4000) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd3000, "speed");
        wr_reg(ramp_pkg::A_CMD, {16'h0, ramp_pkg::CMD_STOP});
        wait_idle;
        total += steps - base;
        wr_reg(ramp_pkg::A_CTL, 24'h60);
        wr_reg(ramp_pkg::A_FH, 24'd4600);
        move(24'd100000, 24'h0);
        repeat (400) @(posedge clk);
        wr_reg(ramp_pkg::A_FH, 24'd5000);
        repeat (2400) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd5000, "speed");
        wr_reg(ramp_pkg::A_FH, 24'd6000);
        repeat (400) @(posedge clk);
        wr_reg(ramp_pkg::A_FH, 24'd3000);
        repeat (5000) @(posedge clk);
        rd_chk(ramp_pkg::A_SPD, 24'd3000, "speed");
        wr_reg(ramp_pkg::A_CMD, {16'h0, ramp_pkg::CMD_STOP});
        wait_idle;
        total += steps - base;
        rd_chk(ramp_pkg::A_CNT, 24'(total), "counter");
        $display("speed change done");
        repeat (2) @(posedge clk);
        nrst <= 1'b0;
        sel <= 1'b1;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK("pins", 10'h3e8, {i_o, w_o, pls, mdir, busy, td, p1, p2, p3, p4})
        rd_chk(ramp_pkg::A_CNT, 24'h0, "counter");
        rd_chk(ramp_pkg::A_FH, 24'h0, "run speed");
        repeat (3) @(posedge clk);
        $display("second reset done");
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
